// ===== hdcw_consts.vh
// Constants for the half-duplex control-word serial port
`ifndef HDCW_CONSTS_VH
`define HDCW_CONSTS_VH
// ============================================================
// Frame shape
`define HDCW_CTRL_BITS   5'd8
`define HDCW_MIN_RESP    5'd4
`define HDCW_MAX_RESP    5'd16
`define HDCW_CNT_ONE     5'd1
`define HDCW_CNT_ZERO    5'd0
// ============================================================
// Serial clock divider: terminal count, half period is this plus one system cycles
`define HDCW_HALF_DIV    4'd9
`define HDCW_DIV_ZERO    4'd0
`define HDCW_WORD_ZERO   16'h0000
`define HDCW_BYTE_ZERO   8'h00
`endif

// ===== hdcw_sync.v
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module hdcw_sync (
  input  wire clock_i,
  input  wire rst_i,
  input  wire d_i,
  input  wire rst_val_i,
  output reg  q_o
);
  reg meta_q;

  // ============================================================
  // Synchroniser chain; first stage is read only by the second
  always @(posedge clock_i) begin
    if (rst_i) begin
      // Park at the pin's idle level so no false edge follows reset
      meta_q <= rst_val_i;
      q_o    <= rst_val_i;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule // hdcw_sync
`default_nettype wire

// ===== hdcw_port.v
// Half-duplex control-word serial port, master and slave modes
//
// Behaviour
// - Each frame opens with an 8-bit control word sent out, and nothing is received during it.
// - The response is 4 to 16 bits, so a frame spans 13 to 25 bit times.
// - When idle the serial clock is low, frame select high and the out line low.
// - A frame starts when a control byte sits in the transmit entry.
// - On frame select falling the entry is loaded and its top bit driven out.
// - Frame select stays low all frame and the in line is not driven during the control word.
// - Response bits change on falling edges and are captured on the next rising edge.
// - A single frame ends with frame select rising one clock after the last capture, in the same cycle as the word is delivered.
// - In continuous mode, while a byte sits in the transmit entry, frame select stays low and the next control byte follows at once.
// - In continuous mode with a next byte in the transmit entry, the received word is delivered on the falling edge after the last capture.
// - As slave the first bit is sampled on the first rising edge after frame select falls.
`timescale 1ns/1ps
`default_nettype none
`include "hdcw_consts.vh"
module hdcw_port (
  input  wire        clock_i,
  input  wire        rst_i,
  input  wire        slave_mode_i,
  input  wire        continuous_i,
  input  wire [4:0]  resp_bits_i,
  input  wire [7:0]  tx_data_i,
  input  wire        tx_valid_i,
  output reg         tx_ready_o,
  output reg  [15:0] rx_data_o,
  output reg         rx_valid_o,
  output reg  [7:0]  slv_ctrl_o,
  output reg         slv_ctrl_valid_o,
  input  wire [15:0] slv_resp_i,
  output reg         busy_o,
  output reg         serial_clock_line_o,
  output reg         serial_clock_line_oe_o,
  input  wire        serial_clock_line_i,
  output reg         frame_sel_n_o,
  output reg         frame_sel_n_oe_o,
  input  wire        frame_sel_n_i,
  output reg         sdo_o,
  output reg         sdo_oe_o,
  input  wire        sdi_i
);
  // ============================================================
  // Master states, one-hot
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_CTRL = 5'b00010;
  localparam [4:0] ST_WAIT = 5'b00100;
  localparam [4:0] ST_RESP = 5'b01000;
  localparam [4:0] ST_END  = 5'b10000;

  reg  [4:0]  state_q;
  reg  [3:0]  div_q;
  reg         phase_q;     // Serial clock level in master mode
  reg  [4:0]  cnt_q;
  reg  [4:0]  len_q;
  reg  [7:0]  tx_sh_q;
  reg  [15:0] rx_sh_q;
  reg  [7:0]  hold_q;      // One-entry transmit store
  reg         hold_v_q;
  reg         sck_d1_q;
  reg         fs_d1_q;
  reg         s_active_q;
  reg         s_resp_q;
  reg  [4:0]  s_cnt_q;
  reg  [15:0] s_sh_q;
  wire        sck_s;
  wire        fs_s;
  wire        sdi_s;
  wire        half_tick;
  wire        rise_tick;
  wire        fall_tick;
  wire        s_rise;
  wire        s_fall;
  wire [4:0]  len_clamped;

  // Clamp data size into the legal response range
  function [4:0] clamp_len;
    input [4:0] v;
    begin
      if (v < `HDCW_MIN_RESP) clamp_len = `HDCW_MIN_RESP;
      else if (v > `HDCW_MAX_RESP) clamp_len = `HDCW_MAX_RESP;
      else clamp_len = v;
    end
  endfunction

  assign len_clamped = clamp_len(resp_bits_i);

  // ============================================================
  // Pin synchronisers
  hdcw_sync u_sync_sck (.clock_i(clock_i), .rst_i(rst_i), .d_i(serial_clock_line_i), .rst_val_i(1'b0), .q_o(sck_s));
  hdcw_sync u_sync_fs  (.clock_i(clock_i), .rst_i(rst_i), .d_i(frame_sel_n_i), .rst_val_i(1'b1), .q_o(fs_s));
  hdcw_sync u_sync_sdi (.clock_i(clock_i), .rst_i(rst_i), .d_i(sdi_i), .rst_val_i(1'b0), .q_o(sdi_s));

  // Half-period divider gives one-cycle enables
  always @(posedge clock_i) begin
    if (rst_i || state_q == ST_IDLE) begin
      div_q <= `HDCW_DIV_ZERO;
    end else if (div_q == `HDCW_HALF_DIV) begin
      div_q <= `HDCW_DIV_ZERO;
    end else begin
      div_q <= div_q + 4'd1;
    end
  end
  assign half_tick = (state_q != ST_IDLE) && (div_q == `HDCW_HALF_DIV);
  assign rise_tick = half_tick && !phase_q;
  assign fall_tick = half_tick && phase_q;

  // ============================================================
  // Transmit store; a write wins room only when empty
  always @(posedge clock_i) begin
    if (rst_i) begin
      hold_q   <= `HDCW_BYTE_ZERO;
      hold_v_q <= 1'b0;
    end else if (tx_valid_i && tx_ready_o) begin
      hold_q   <= tx_data_i;
      hold_v_q <= 1'b1;
    end else if (state_q == ST_IDLE && hold_v_q && !slave_mode_i) begin
      hold_v_q <= 1'b0;
    end else if (fall_tick && state_q == ST_RESP && cnt_q == `HDCW_CNT_ONE && continuous_i) begin
      hold_v_q <= 1'b0;
    end
  end

  // ============================================================
  // Master frame sequencer
  always @(posedge clock_i) begin
    if (rst_i || slave_mode_i) begin
      state_q    <= ST_IDLE;
      phase_q    <= 1'b0;
      cnt_q      <= `HDCW_CNT_ZERO;
      len_q      <= `HDCW_MIN_RESP;
      tx_sh_q    <= `HDCW_BYTE_ZERO;
      rx_sh_q    <= `HDCW_WORD_ZERO;
      rx_valid_o <= 1'b0;
      rx_data_o  <= `HDCW_WORD_ZERO;
    end else begin
      rx_valid_o <= 1'b0;
      if (half_tick) phase_q <= ~phase_q;
      case (state_q)
        ST_IDLE: begin
          phase_q <= 1'b0;
          if (hold_v_q) begin
            tx_sh_q <= hold_q;
            rx_sh_q <= `HDCW_WORD_ZERO; // Short words read back zero-filled
            cnt_q   <= `HDCW_CTRL_BITS;
            len_q   <= len_clamped;
            state_q <= ST_CTRL;
          end
        end
        ST_CTRL: begin
          // Far end captures on the rise; shift on the fall
          if (fall_tick) begin
            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            if (cnt_q == `HDCW_CNT_ONE) state_q <= ST_WAIT;
            else cnt_q <= cnt_q - 5'd1;
          end
        end
        ST_WAIT: begin
          // One idle serial clock while the far end decodes
          if (fall_tick) begin
            cnt_q   <= len_q;
            state_q <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (rise_tick) rx_sh_q <= {rx_sh_q[14:0], sdi_s};
          if (fall_tick) begin
            if (cnt_q == `HDCW_CNT_ONE) begin
              if (continuous_i && hold_v_q) begin
                rx_data_o  <= rx_sh_q;
                rx_valid_o <= 1'b1;
                tx_sh_q    <= hold_q;
                rx_sh_q    <= `HDCW_WORD_ZERO;
                cnt_q      <= `HDCW_CTRL_BITS;
                len_q      <= len_clamped;
                state_q    <= ST_CTRL;
              end else begin
                state_q <= ST_END;
              end
            end else begin
              cnt_q <= cnt_q - 5'd1;
            end
          end
        end
        ST_END: begin
          // Clock rests low half a period, then select rises; no extra pulse
          if (half_tick) begin
            rx_data_o  <= rx_sh_q;
            rx_valid_o <= 1'b1;
            state_q    <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ============================================================
  // Slave receiver: control word in, response out
  always @(posedge clock_i) begin
    if (rst_i || !slave_mode_i) begin
      sck_d1_q         <= 1'b0;
      fs_d1_q          <= 1'b1;
      s_active_q       <= 1'b0;
      s_resp_q         <= 1'b0;
      s_cnt_q          <= `HDCW_CNT_ZERO;
      s_sh_q           <= `HDCW_WORD_ZERO;
      slv_ctrl_o       <= `HDCW_BYTE_ZERO;
      slv_ctrl_valid_o <= 1'b0;
    end else begin
      sck_d1_q         <= sck_s;
      fs_d1_q          <= fs_s;
      slv_ctrl_valid_o <= 1'b0;
      if (fs_s) begin
        s_active_q <= 1'b0;
        s_resp_q   <= 1'b0;
      end else if (fs_d1_q) begin
        s_active_q <= 1'b1;
        s_cnt_q    <= `HDCW_CNT_ZERO;
      end else if (s_active_q && !s_resp_q && s_rise) begin
        s_sh_q  <= {s_sh_q[14:0], sdi_s};
        s_cnt_q <= s_cnt_q + 5'd1;
        if (s_cnt_q == `HDCW_CTRL_BITS - 5'd1) begin
          slv_ctrl_o       <= {s_sh_q[6:0], sdi_s};
          slv_ctrl_valid_o <= 1'b1;
          s_resp_q         <= 1'b1;
          s_cnt_q          <= `HDCW_CNT_ZERO;
        end
      end else if (s_resp_q && s_fall) begin
        // First fall opens the wait clock; the word loads on the wait fall
        if (s_cnt_q == `HDCW_CNT_ONE) s_sh_q <= slv_resp_i;
        else if (s_cnt_q != `HDCW_CNT_ZERO) s_sh_q <= {s_sh_q[14:0], 1'b0};
        s_cnt_q <= s_cnt_q + 5'd1;
        if (s_cnt_q == len_clamped + `HDCW_CNT_ONE) begin
          s_resp_q   <= 1'b0; // Back to control word
          s_cnt_q    <= `HDCW_CNT_ZERO;
        end
      end
    end
  end
  assign s_rise = sck_s && !sck_d1_q;
  assign s_fall = !sck_s && sck_d1_q;

  // ============================================================
  // Registered pin and status drive
  always @(posedge clock_i) begin
    if (rst_i) begin
      serial_clock_line_o    <= 1'b0;
      serial_clock_line_oe_o <= 1'b0;
      frame_sel_n_o          <= 1'b1;
      frame_sel_n_oe_o       <= 1'b0;
      sdo_o                  <= 1'b0;
      sdo_oe_o               <= 1'b0;
      tx_ready_o             <= 1'b0;
      busy_o                 <= 1'b0;
    end else begin
      serial_clock_line_oe_o <= !slave_mode_i;
      frame_sel_n_oe_o       <= !slave_mode_i;
      serial_clock_line_o    <= (state_q == ST_IDLE || state_q == ST_END) ? 1'b0 :
                                (half_tick ? ~phase_q : phase_q);
      frame_sel_n_o          <= ((state_q == ST_IDLE) && !(hold_v_q && !slave_mode_i)) ||
                                ((state_q == ST_END) && half_tick);
      if (slave_mode_i) begin
        sdo_oe_o <= s_resp_q && !fs_s;
        sdo_o    <= s_resp_q && (s_cnt_q > `HDCW_CNT_ONE) && s_sh_q[15];
      end else begin
        sdo_oe_o <= 1'b1;
        // Control bits only; low in wait and response, and in idle unless a byte waits
        sdo_o    <= ((state_q == ST_CTRL) || (state_q == ST_IDLE && hold_v_q)) ?
                    ((state_q == ST_IDLE) ? hold_q[7] : tx_sh_q[7]) : 1'b0;
      end
      tx_ready_o <= !hold_v_q && !(tx_valid_i && tx_ready_o);
      busy_o     <= (state_q != ST_IDLE) || s_active_q;
    end
  end
endmodule // hdcw_port
`default_nettype wire

// ===== hdcw_chk_sva.sv
// Pin-level checks on the control-word serial port
`timescale 1ns/1ps
`default_nettype none
module hdcw_chk (
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic [4:0] resp_bits_i,
  input wire logic [7:0] tx_data_i,
  input wire logic       tx_valid_i,
  input wire logic       tx_ready_o,
  input wire logic       rx_valid_o,
  input wire logic       busy_o,
  input wire logic       serial_clock_line_o,
  input wire logic       frame_sel_n_o,
  input wire logic       sdo_o
);
  // ==========================================
  // Helpers: ages saturate so a stuck clock cannot wrap into range
  logic [7:0] byte_q, rage_q, rises_q;
  logic       sck_q;
  wire  [5:0] flen = (resp_bits_i < 5'd4) ? 6'd13 : (resp_bits_i > 5'd16) ? 6'd25 : {1'b0, resp_bits_i} + 6'd9;
  wire        rise = serial_clock_line_o & ~sck_q;
  always @(posedge clock_i) begin
    sck_q   <= rst_i ? 1'b0 : serial_clock_line_o;
    rage_q  <= rst_i | rise ? 8'h00 : rage_q + {7'h00, rage_q != 8'hff};
    rises_q <= rst_i | frame_sel_n_o ? 8'h00 : rises_q + {7'h00, rise};
    if (tx_valid_i & tx_ready_o) byte_q <= tx_data_i;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // Assertions
  a_idle_lines_low: assert property (frame_sel_n_o & ~busy_o |-> ~serial_clock_line_o & ~sdo_o)
    else $error("idle lines not low");
  a_frame_start: assert property (tx_valid_i & tx_ready_o & frame_sel_n_o & ~busy_o |-> ##[1:4] $fell(frame_sel_n_o))
    else $error("frame did not start");
  a_start_msb: assert property ($fell(frame_sel_n_o) |-> sdo_o == byte_q[7])
    else $error("first bit not msb");
  a_sck_in_frame: assert property ($rose(serial_clock_line_o) |-> ~frame_sel_n_o)
    else $error("clock outside frame");
  a_frame_bits: assert property ($rose(frame_sel_n_o) |-> rises_q != 0 && rises_q % flen == 0)
    else $error("wrong clock count");
  a_sel_rise_late: assert property ($rose(frame_sel_n_o) |-> rage_q >= 14 && rage_q <= 26)
    else $error("select rise mistimed");
  a_word_out: assert property ($rose(frame_sel_n_o) |-> ##[0:4] rx_valid_o)
    else $error("word not delivered");
  a_chain_word: assert property (rx_valid_o & ~frame_sel_n_o |-> $fell(serial_clock_line_o))
    else $error("chained word mistimed");
endmodule // hdcw_chk
bind hdcw_port hdcw_chk i_chk (.clock_i(clock_i), .rst_i(rst_i), .resp_bits_i(resp_bits_i),
  .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o),
  .busy_o(busy_o), .serial_clock_line_o(serial_clock_line_o), .frame_sel_n_o(frame_sel_n_o), .sdo_o(sdo_o));
`default_nettype wire

// ===== hdcw_slave.sv
// Off-chip slave model answering each control byte with a derived word
`timescale 1ns/1ps
`default_nettype none
module hdcw_slave (
  input  wire logic       sck_i,
  input  wire logic       sel_n_i,
  input  wire logic       sdo_i,
  input  wire logic [4:0] len_i,
  output var  logic       sdi_o,
  output var  logic [7:0] ctrl_o,
  output var  logic       ev_o
);
  int          cnt = 0;
  logic [15:0] resp;
  initial sdi_o = 1'b0;
  initial ev_o = 1'b0;
  // Count rises; control bits land on the first eight
  always @(posedge sck_i) begin
    cnt = sel_n_i ? 0 : cnt + 1;
    if (cnt >= 1 && cnt <= 8) ctrl_o = {ctrl_o[6:0], sdo_i};
    if (cnt == 8) begin
      resp = {ctrl_o, ~ctrl_o};
      ev_o = 1'b1;
      #1 ev_o = 1'b0;
    end
    if (cnt == 9 + len_i) cnt = 0;
  end
  // Answer after the wait clock; a released line toggles since no pull holds it
  always @(negedge sck_i or posedge sel_n_i) begin
    if (!sel_n_i && cnt >= 9 && cnt < 9 + len_i) sdi_o = resp[24 - cnt];
    else sdi_o = ~sdi_o;
  end
endmodule // hdcw_slave
`default_nettype wire

// ===== hdcw_port_tb_top.sv
// Bench for the control-word serial port in master and slave roles
`timescale 1ns/1ps
`default_nettype none
module hdcw_port_tb_top;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cont = 1'b0;
  logic [4:0]  rbits = 5'h04;
  logic [7:0]  txd = 8'h00;
  logic        txv = 1'b0;
  logic        txr, rxv, busy, sck, sck_oe, sel, sel_oe, sdo, sdo_oe, sdi, ev;
  logic [15:0] rxd;
  logic [7:0]  ctrl;
  logic [15:0] exp_rx[$];
  logic [7:0]  exp_ctrl[$];
  int          seed, num_errors, checks_done, rx_seen, i;
  logic [4:0]  len;
  // Outside master lines for the slave-role frames
  logic        smode = 1'b0;
  logic        msck = 1'b0;
  logic        msel = 1'b1;
  logic        msdi = 1'b0;
  logic [15:0] sresp = 16'h0000;
  logic [15:0] sgot;
  logic [7:0]  sctrl, exp_sctrl;
  logic        sctv;
  int          sct_seen;
  wire         sck_w = sck_oe ? sck : msck;
  wire         sel_w = sel_oe ? sel : msel;
  wire         sdi_w = smode ? msdi : sdi;
  always #2 clock_i = ~clock_i;
  hdcw_port i_dut (.clock_i(clock_i), .rst_i(rst_i), .slave_mode_i(smode), .continuous_i(cont),
    .resp_bits_i(rbits), .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(txr), .rx_data_o(rxd),
    .rx_valid_o(rxv), .slv_ctrl_o(sctrl), .slv_ctrl_valid_o(sctv), .slv_resp_i(sresp), .busy_o(busy),
    .serial_clock_line_o(sck), .serial_clock_line_oe_o(sck_oe), .serial_clock_line_i(sck_w),
    .frame_sel_n_o(sel), .frame_sel_n_oe_o(sel_oe), .frame_sel_n_i(sel_w), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .sdi_i(sdi_w));
  // Slave model kept deselected while the port itself plays slave
  hdcw_slave i_slave (.sck_i(sck_w), .sel_n_i(smode | sel_w), .sdo_i(sdo), .len_i(rbits), .sdi_o(sdi),
    .ctrl_o(ctrl), .ev_o(ev));
  // ==========================================
  // Helpers
  function automatic logic [15:0] exp_word(input logic [7:0] b, input logic [4:0] n);
    logic [15:0] r;
    r = {b, ~b};
    return r >> (5'd16 - n);
  endfunction
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hold the strobe until the port takes the byte
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    exp_ctrl.push_back(b);
    exp_rx.push_back(exp_word(b, len));
    txd <= b;
    txv <= 1'b1;
    @(posedge clock_i);
    while (txr !== 1'b1 && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    txv <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic wait_rx(input int k);
    int n;
    n = 0;
    while (rx_seen < k && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    chk("rx_count", 16'(k), 16'(rx_seen));
  endtask
  // One frame from an outside master; its clock parks low between frames
  task automatic mframe(input logic [7:0] c, input logic [4:0] n);
    int j;
    exp_sctrl = c;
    sgot = 16'h0000;
    sresp <= {c, ~c};
    rbits <= n;
    msel <= 1'b0;
    repeat (40) @(posedge clock_i);
    for (j = 0; j < 9 + n; j++) begin
      msdi <= (j < 8) ? c[7 - j] : 1'b0;
      repeat (10) @(posedge clock_i);
      msck <= 1'b1;
      if (j == 0) chk("sdo_oe_ctrl", 16'h0000, {15'h0000, sdo_oe});
      if (j > 8) sgot = {sgot[14:0], sdo};
      if (j == 9) chk("sdo_oe_resp", 16'h0001, {15'h0000, sdo_oe});
      repeat (10) @(posedge clock_i);
      msck <= 1'b0;
    end
    repeat (20) @(posedge clock_i);
    msel <= 1'b1;
    chk("slv_resp", exp_word(c, n), sgot);
    repeat (40) @(posedge clock_i);
  endtask
  // Words and control bytes against what was sent
  always @(posedge clock_i) begin
    if (rxv === 1'b1) begin
      rx_seen++;
      chk("rx_word", exp_rx.size() ? exp_rx.pop_front() : 16'hxxxx, rxd);
    end
    if (sctv === 1'b1) begin
      sct_seen++;
      chk("slv_ctrl", {8'h00, exp_sctrl}, {8'h00, sctrl});
    end
  end
  always @(posedge ev) chk("ctrl", {8'h00, exp_ctrl.size() ? exp_ctrl.pop_front() : 8'hxx}, {8'h00, ctrl});
  // ==========================================
  // Main sequence
  initial begin
    seed = 9705;
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk("idle_pins", 16'h0004, {13'h0000, sel_w, sck_w, sdo});
    // Single frames: both length bounds, then random lengths
    for (i = 0; i < 8; i++) begin
      len = (i == 0) ? 5'd4 : (i == 1) ? 5'd16 : 5'd4 + 5'($unsigned($random(seed)) % 13);
      rbits <= len;
      send((i == 0) ? 8'hff : 8'($random(seed)));
      wait_rx(i + 1);
    end
    // Chained frames, next byte queued while one is in flight
    cont <= 1'b1;
    len = 5'd12;
    rbits <= len;
    send(8'h00);
    send(8'ha5);
    send(8'($random(seed)));
    wait_rx(11);
    cont <= 1'b0;
    // Slave role: an outside master clocks three frames in
    smode <= 1'b1;
    repeat (4) @(posedge clock_i);
    for (i = 0; i < 3; i++) begin
      len = (i == 0) ? 5'd4 : (i == 1) ? 5'd16 : 5'd4 + 5'($unsigned($random(seed)) % 13);
      mframe((i == 0) ? 8'h81 : 8'($random(seed)), len);
    end
    chk("slv_ctrl_count", 16'h0003, 16'(sct_seen));
    summarize();
  end
  // Watchdog far beyond the fourteen frames of the run
  initial begin
    repeat (40000) @(posedge clock_i);
    num_errors++;
    summarize();
  end
endmodule // hdcw_port_tb_top
`default_nettype wire
